/* File: mia_indirect_regs.sv */
`timescale 1ns/1ps
`include "mia_consts.svh"

module mia_indirect_regs
  import mia_pkg::*;
#(
  parameter int DEV_COUNT = 32
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire mia_mgmt_req_t mgmt_req,
  output logic [15:0] mgmt_rdata,
  output logic mgmt_rvalid,
  output mia_mmd_req_t mmd_req,
  input wire logic [15:0] mmd_rdata
);

  // ==========================================================================
  // State
  logic [15:0] ctrl_reg;
  logic [15:0] addr_mem_reg [DEV_COUNT];
  mia_mmd_req_t mmd_req_reg;
  logic rd_pend_reg;
  logic rd_from_dev_reg;
  logic [15:0] rd_word_reg;
  logic [15:0] mgmt_rdata_reg;
  logic mgmt_rvalid_reg;

  // Decode and next-value nets
  logic [4:0] dev_sel;
  mia_op_t op_sel;
  logic [15:0] cur_addr;
  logic hit_ctrl;
  logic hit_ad;
  logic hit_ext;
  logic data_mode;
  logic step_addr;
  logic addr_load;
  logic [15:0] addr_next;
  logic [15:0] rd_word_next;

  // ==========================================================================
  // Helpers
  // Small decode helpers shared by several processes
  // Index match of one management access
  function automatic logic reg_hit(logic [4:0] idx, logic [4:0] want);
  begin
    return idx == want;
  end
  endfunction

  // Access to the address/data register that moves target data
  function automatic logic data_hit(logic hit, logic mode);
  begin
    return hit && mode;
  end
  endfunction

  // Which accesses advance the latched address, per operation
  function automatic logic op_steps(mia_op_t op, logic wr, logic rd);
    logic steps;
  begin
    steps = 1'b0;
    unique case (op)
      MIA_OP_REG: steps = 1'b0; // Address accesses never step
      MIA_OP_DATA_FIXED: steps = 1'b0;
      MIA_OP_DATA_INC_RW: steps = wr | rd;
      MIA_OP_DATA_INC_WR: steps = wr;
    endcase
    return steps;
  end
  endfunction

  // ==========================================================================
  // Field decode
  // Target and operation come straight from the stored control word
  assign dev_sel = ctrl_reg[`MIA_DEV_HI:`MIA_DEV_LO];
  assign op_sel = mia_op_t'(ctrl_reg[`MIA_OP_HI:`MIA_OP_LO]);
  assign cur_addr = addr_mem_reg[dev_sel];

  // Register index matches
  assign hit_ctrl = reg_hit(mgmt_req.addr, `MIA_REG_CTRL);
  assign hit_ad = reg_hit(mgmt_req.addr, `MIA_REG_ADDR_DATA);
  assign hit_ext = reg_hit(mgmt_req.addr, `MIA_REG_EXT_STATUS);
  assign data_mode = op_sel != MIA_OP_REG;

  // Post-increment only on the address/data register
  always_comb
  begin
    step_addr = 1'b0;
    if (hit_ad)
      step_addr = op_steps(op_sel, mgmt_req.wr, mgmt_req.rd);
  end

  // ==========================================================================
  // Access control register, all 16 bits stored
  // Reserved bits kept so software reads back what it wrote
  always_ff @(posedge mclk)
  begin
    if (rst)
      ctrl_reg <= `MIA_CTRL_RESET;
    else if (mgmt_req.wr && hit_ctrl)
      ctrl_reg <= mgmt_req.wdata;
  end

  // ==========================================================================
  // Latched address per target device
  // Load in register mode, step in the incrementing data modes
  always_comb
  begin
    addr_load = 1'b0;
    addr_next = cur_addr;
    if (mgmt_req.wr && hit_ad && !data_mode)
    begin
      addr_load = 1'b1;
      addr_next = mgmt_req.wdata;
    end
    else if (step_addr)
    begin
      addr_load = 1'b1;
      addr_next = cur_addr + `MIA_ADDR_STEP; // Wraps at 16 bits
    end
  end

  // One word per device, so switching targets keeps each address
  // Reset clears every device's address
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      for (int i = 0; i < DEV_COUNT; i++)
        addr_mem_reg[i] <= `MIA_ADDR_DATA_RESET;
    end
    else if (addr_load)
      addr_mem_reg[dev_sel] <= addr_next;
  end

  // ==========================================================================
  // Data transfer toward the selected device, one cycle after the access
  // Address sent is the one before any step
  always_ff @(posedge mclk)
  begin
    if (rst)
      mmd_req_reg <= '0;
    else
    begin
      mmd_req_reg.wr <= mgmt_req.wr && data_hit(hit_ad, data_mode);
      mmd_req_reg.rd <= mgmt_req.rd && data_hit(hit_ad, data_mode);
      mmd_req_reg.dev <= dev_sel;
      mmd_req_reg.reg_addr <= cur_addr; // Address before any step
      mmd_req_reg.wdata <= mgmt_req.wdata;
    end
  end

  // Target request straight from its flip-flops
  assign mmd_req = mmd_req_reg;

  // ==========================================================================
  // Read path
  // Read answer two cycles after the request
  // Register-side answer word, chosen while the index stands
  always_comb
  begin
    rd_word_next = `MIA_ZERO_WORD; // Unmapped indices read zero
    if (hit_ctrl)
      rd_word_next = ctrl_reg;
    else if (hit_ad)
      rd_word_next = cur_addr;
    else if (hit_ext)
      rd_word_next = `MIA_EXT_STATUS_VALUE;
  end

  // Read stage one: remember the source
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rd_pend_reg <= 1'b0;
      rd_from_dev_reg <= 1'b0;
      rd_word_reg <= `MIA_ZERO_WORD;
    end
    else
    begin
      rd_pend_reg <= mgmt_req.rd;
      rd_from_dev_reg <= data_hit(hit_ad, data_mode);
      rd_word_reg <= rd_word_next;
    end
  end

  // Read stage two: answer, device data taken while its read strobe stands
  // Source flag picks device data or register word
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      mgmt_rvalid_reg <= 1'b0;
      mgmt_rdata_reg <= `MIA_ZERO_WORD;
    end
    else
    begin
      mgmt_rvalid_reg <= rd_pend_reg;
      if (rd_pend_reg)
        mgmt_rdata_reg <= rd_from_dev_reg ? mmd_rdata : rd_word_reg;
    end
  end

  // Answer outputs straight from flip-flops
  assign mgmt_rvalid = mgmt_rvalid_reg;
  assign mgmt_rdata = mgmt_rdata_reg;

endmodule

/* File: mia_consts.svh */
`ifndef MIA_CONSTS_SVH
`define MIA_CONSTS_SVH

// ==========================================================================
// Management register indices
`define MIA_REG_CTRL 5'h0d
`define MIA_REG_ADDR_DATA 5'h0e
`define MIA_REG_EXT_STATUS 5'h0f

// ==========================================================================
// Access control register fields
`define MIA_OP_HI 15
`define MIA_OP_LO 14
`define MIA_RSVD_HI 13
`define MIA_RSVD_LO 5
`define MIA_DEV_HI 4
`define MIA_DEV_LO 0
`define MIA_CTRL_RESET 16'h0000
`define MIA_ADDR_DATA_RESET 16'h0000

// ==========================================================================
// Extended status value: 1000Base-X none, 1000Base-T full and half
`define MIA_EXT_STATUS_VALUE 16'h3000

// ==========================================================================
// Misc
`define MIA_ADDR_STEP 16'h0001
`define MIA_ZERO_WORD 16'h0000

`endif

/* File: mia_pkg.sv */
package mia_pkg;

  // ==========================================================================
  // Operation select codes
  typedef enum logic [1:0] {
    MIA_OP_REG = 2'h0,
    MIA_OP_DATA_FIXED = 2'h1,
    MIA_OP_DATA_INC_RW = 2'h2,
    MIA_OP_DATA_INC_WR = 2'h3
  } mia_op_t;

  // ==========================================================================
  // Management register access request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic [15:0] wdata;
  } mia_mgmt_req_t;

  // ==========================================================================
  // Access toward the extended register space
  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] dev;
    logic [15:0] reg_addr;
    logic [15:0] wdata;
  } mia_mmd_req_t;

endpackage

/* File: mia_mmd_model.sv */
`timescale 1ns/1ps
// ====
// Target space model
module mia_mmd_model
  import mia_pkg::*;
(
  input wire logic mclk,
  input wire mia_mmd_req_t mmd_req,
  output logic [15:0] mmd_rdata
);
  logic [15:0] mem_reg [16];
  // Store data writes
  always_ff @(posedge mclk)
  begin
    if (mmd_req.wr)
      mem_reg[mmd_req.reg_addr[3:0]] <= mmd_req.wdata;
  end
  // Valid only while read strobed
  assign mmd_rdata = mmd_req.rd ? mem_reg[mmd_req.reg_addr[3:0]] : 16'hdead;
endmodule

/* File: mia_indirect_regs_asserts.sv */
`timescale 1ns/1ps
// ====
// Port checker
module mia_indirect_regs_asserts
  import mia_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire mia_mgmt_req_t mgmt_req,
  input wire logic [15:0] mgmt_rdata,
  input wire logic mgmt_rvalid,
  input wire mia_mmd_req_t mmd_req,
  input wire logic [15:0] mmd_rdata
);
  logic [15:0] ctrl_reg;
  wire acc = mmd_req.rd || mmd_req.wr;
  wire ea = mgmt_req.addr == 5'h0e;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Shadow of control register
  always_ff @(posedge mclk)
  begin
    if (rst)
      ctrl_reg <= 16'h0000;
    else if (mgmt_req.wr && mgmt_req.addr == 5'h0d)
      ctrl_reg <= mgmt_req.wdata;
  end
  sequence s_rd_acc(logic [1:0] op);
    (mmd_req.rd && ctrl_reg[15:14] == op) ##1 acc;
  endsequence
  property p_fix; s_rd_acc(2'h1) |-> $stable(mmd_req.reg_addr); endproperty
  a_fix: assert property (p_fix) else $error("address moved");
  property p_inc; s_rd_acc(2'h2) |-> mmd_req.reg_addr == $past(mmd_req.reg_addr) + 16'h1;
  endproperty
  a_inc: assert property (p_inc) else $error("no advance");
  property p_wronly; s_rd_acc(2'h3) |-> $stable(mmd_req.reg_addr); endproperty
  a_wronly: assert property (p_wronly) else $error("read advanced");
  property p_ext; mgmt_req.rd && mgmt_req.addr == 5'h0f |-> ##2 mgmt_rdata == 16'h3000;
  endproperty
  a_ext: assert property (p_ext) else $error("status value");
  property p_ans; mgmt_req.rd |-> ##2 mgmt_rvalid; endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_drd; mmd_req.rd |=> mgmt_rvalid && mgmt_rdata == $past(mmd_rdata); endproperty
  a_drd: assert property (p_drd) else $error("data read");
  property p_dwr; mgmt_req.wr && ea && ctrl_reg[15:14] != 2'h0 |=> mmd_req.wr
    && mmd_req.wdata == $past(mgmt_req.wdata) && mmd_req.dev == $past(ctrl_reg[4:0]);
  endproperty
  a_dwr: assert property (p_dwr) else $error("data write");
  property p_regm; (mgmt_req.wr || mgmt_req.rd) && ea && ctrl_reg[15:14] == 2'h0 |=> !acc;
  endproperty
  a_regm: assert property (p_regm) else $error("register mode");
endmodule
bind mia_indirect_regs mia_indirect_regs_asserts mia_indirect_regs_asserts_i (.mclk(mclk),
  .rst(rst), .mgmt_req(mgmt_req), .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid),
  .mmd_req(mmd_req), .mmd_rdata(mmd_rdata));

/* File: mia_indirect_regs_test.sv */
`timescale 1ns/1ps
// ====
// Testbench
module mia_indirect_regs_test import mia_pkg::*;;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  mia_mgmt_req_t req = '0;
  logic [15:0] rdata, mrd;
  logic rv;
  mia_mmd_req_t mreq;
  int mismatches = 0;
  int samples_checked = 0;
  always #12.5 mclk = ~mclk;
  mia_indirect_regs mia_indirect_regs_i (.mclk(mclk), .rst(rst), .mgmt_req(req),
    .mgmt_rdata(rdata), .mgmt_rvalid(rv), .mmd_req(mreq), .mmd_rdata(mrd));
  mia_mmd_model mia_mmd_model_i (.mclk(mclk), .mmd_req(mreq), .mmd_rdata(mrd));
  task chk(logic [15:0] got, logic [15:0] exp);
  begin
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  end
  endtask
  // Request held n cycles, then settle
  task acc(logic w, logic [4:0] a, logic [15:0] d, int n);
  begin
    req <= '{w, !w, a, d};
    repeat (n) @(posedge mclk);
    req <= '0;
    repeat (4) @(posedge mclk);
  end
  endtask
  // Read one register: answer two cycles on, valid for one cycle
  task rdchk(logic [4:0] a, logic [15:0] exp);
  begin
    req <= '{1'b0, 1'b1, a, 16'h0000};
    @(posedge mclk);
    req <= '0;
    @(posedge mclk);
    #1;
    chk(16'(rv), 16'h0001);
    chk(rdata, exp);
    @(posedge mclk);
    #1;
    chk(16'(rv), 16'h0000);
    repeat (2) @(posedge mclk);
  end
  endtask
  task t_reset;
  begin
    rdchk(5'h0d, 16'h0000);
    rdchk(5'h0e, 16'h0000);
    rdchk(5'h0f, 16'h3000);
    rdchk(5'h00, 16'h0000);
    $display("reset test done");
  end
  endtask
  task t_regs;
  begin
    acc(1'b1, 5'h0d, 16'h3fe5, 1);
    rdchk(5'h0d, 16'h3fe5);
    acc(1'b1, 5'h0e, 16'h1234, 1);
    rdchk(5'h0e, 16'h1234);
    acc(1'b1, 5'h0f, 16'hffff, 1);
    rdchk(5'h0f, 16'h3000);
    $display("register test done");
  end
  endtask
  // Each data mode: write, two back-to-back reads, then latched address
  task t_modes;
  begin
    for (int k = 1; k < 4; k++)
    begin
      acc(1'b1, 5'h0d, 16'h0003, 1);
      acc(1'b1, 5'h0e, 16'h0004, 1);
      acc(1'b1, 5'h0d, {k[1:0], 14'h0003}, 1);
      rdchk(5'h0d, {k[1:0], 14'h0003});
      acc(1'b1, 5'h0e, 16'h00a1, 1);
      acc(1'b0, 5'h0e, 16'h0000, 2);
      if (k == 1)
        chk(rdata, 16'h00a1);
      acc(1'b1, 5'h0d, 16'h0003, 1);
      rdchk(5'h0e, 16'h0004 + {14'h0, k == 2, k > 1});
    end
    $display("mode test done");
  end
  endtask
  task test_done;
  begin
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  end
  endtask
  // Watchdog, about twenty times the expected run
  initial
  begin
    #100us;
    mismatches++;
    test_done;
  end
  initial
  begin
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    t_reset;
    t_regs;
    t_modes;
    test_done;
  end
endmodule
